// File: logic/cla_axis_settings.sv
// Purpose: closed-loop and chopper settings bank for one stepper axis
// Assumes: one clock, synchronous active-high reset, classic wishbone
// Notes: ack one cycle after request, always answers, unmapped reads 0
// Function
// - loop enable bit switches closed loop
// - init flag reads 0 until init done
// - subdivision code selects 2^code microsteps
// - mode bit picks hysteresis or constant off
// - comparator off bit stops decay end in constant off mode
// - 4-bit field: hysteresis end or decay time
// - 0..8 field: hysteresis start or sine offset
// - 2-bit blank time code passed on
// - applied gain is setting over 65536
// - no current ramp inside startup window
// - target reached only within arrival window
// - integral sum clipped to configured limit
// - derivative evaluated on divided rate
// - velocity capped at max plus clip
// - current up/down paced by own delays
// - averaged and raw encoder speed readable
// - relative origin: target, actual, encoder
`timescale 1ns/1ps
module cla_axis_settings #(
	parameter int INIT_LEN = int'(cla_pkg::INIT_CYCLES)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [31:0] speed_avg_i,
	input wire logic [31:0] speed_raw_i,
	input wire logic [31:0] pos_dev_i,
	input wire logic [31:0] vel_max_i,
	input wire logic [31:0] vel_req_i,
	input wire logic [31:0] vel_err_i,
	input wire logic cur_up_req_i,
	input wire logic cur_down_req_i,
	input wire cla_pkg::cla_pos_t pos_i,
	output cla_pkg::cla_chop_t chop_o,
	output logic loop_closure_o,
	output logic [31:0] rel_origin_o,
	output logic [23:0] applied_gain_int_o,
	output logic [15:0] applied_gain_frac_o,
	output logic current_ramp_ok_o,
	output logic target_reached_o,
	output logic [31:0] vel_limited_o,
	output logic [31:0] integ_sum_o,
	output logic deriv_tick_o,
	output logic cur_up_step_o,
	output logic cur_down_step_o
);
	import cla_pkg::*;

	////////////////////////////////////////////////////////////////////
	// register storage
	logic [23:0] igain_r;
	logic [14:0] iclip_r;
	logic [14:0] ddiv_r;
	logic [30:0] vdev_r;
	logic [23:0] up_dly_r;
	logic [23:0] dn_dly_r;
	logic [23:0] pgain_r;
	logic [7:0] tol_r;
	logic [7:0] swin_r;
	logic [1:0] origin_r;
	logic loop_en_r;
	logic [30:0] awin_r;
	logic [31:0] fwait_r;
	logic [31:0] fsel_r;
	logic [31:0] fint_r;
	logic [3:0] sub_r;
	logic [1:0] blank_r;
	logic mode_r;
	logic cmpoff_r;
	logic [3:0] hend_r;
	logic [3:0] hstr_r;
	logic init_done_r;
	logic ack_r;
	logic [31:0] rdat_r;

	////////////////////////////////////////////////////////////////////
	// bus decode
	// ack_r low gates req, so a request held past its ack is taken again every other cycle
	wire req = wb_cyc_i && wb_stb_i && !ack_r;
	wire [7:0] idx = wb_adr_i[9:2];
	// no byte lanes kept: partial writes are dropped
	wire wr = req && wb_we_i && (wb_sel_i == 4'hf);
	wire [31:0] d = wb_dat_i;
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0;
		unique case (idx)
			IDX_VL_IGAIN: rmux = {8'h0, igain_r};
			IDX_VL_ICLIP: rmux = {17'h0, iclip_r};
			IDX_VL_DDIV: rmux = {17'h0, ddiv_r};
			IDX_VDEV_CLIP: rmux = {1'b0, vdev_r};
			IDX_CUR_UP_DLY: rmux = {8'h0, up_dly_r};
			IDX_CUR_DN_DLY: rmux = {8'h0, dn_dly_r};
			IDX_POS_GAIN: rmux = {8'h0, pgain_r};
			IDX_CORR_TOL: rmux = {24'h0, tol_r};
			IDX_STARTUP_WIN: rmux = {24'h0, swin_r};
			IDX_REL_ORIGIN: rmux = {30'h0, origin_r};
			IDX_LOOP_EN: rmux = {31'h0, loop_en_r};
			IDX_SPEED_AVG: rmux = speed_avg_i;
			IDX_SPEED_RAW: rmux = speed_raw_i;
			IDX_INIT_DONE: rmux = {31'h0, init_done_r};
			IDX_ARRIVAL_WIN: rmux = {1'b0, awin_r};
			IDX_FILT_WAIT: rmux = fwait_r;
			IDX_FILT_SEL: rmux = fsel_r;
			IDX_FILT_INT: rmux = fint_r;
			IDX_STEP_SUB: rmux = {28'h0, sub_r};
			IDX_BLANK: rmux = {30'h0, blank_r};
			IDX_CHOP_MODE: rmux = {31'h0, mode_r};
			IDX_FD_CMP_OFF: rmux = {31'h0, cmpoff_r};
			IDX_HEND_FDT: rmux = {28'h0, hend_r};
			IDX_HSTR_SOFS: rmux = {28'h0, hstr_r};
			default: rmux = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h0;
		end else begin
			ack_r <= req;
			rdat_r <= req ? rmux : 32'h0;
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	////////////////////////////////////////////////////////////////////
	// writes; read-only indices have no write branch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			igain_r <= 24'h0;
			iclip_r <= 15'h0;
			ddiv_r <= 15'h0;
			vdev_r <= 31'h0;
			up_dly_r <= 24'h0;
			dn_dly_r <= 24'h0;
			pgain_r <= 24'h0;
			tol_r <= 8'h0;
			swin_r <= 8'h0;
			origin_r <= 2'h0;
			loop_en_r <= 1'b0;
			awin_r <= 31'h0;
			fwait_r <= 32'h0;
			fsel_r <= 32'h0;
			fint_r <= 32'h0;
			sub_r <= STEP_SUB_RST;
			blank_r <= 2'h0;
			mode_r <= 1'b0;
			cmpoff_r <= 1'b0;
			hend_r <= 4'h0;
			hstr_r <= 4'h0;
		end else if (wr) begin
			unique case (idx)
				IDX_VL_IGAIN: igain_r <= d[23:0];
				IDX_VL_ICLIP: iclip_r <= d[14:0];
				IDX_VL_DDIV: ddiv_r <= d[14:0];
				IDX_VDEV_CLIP: vdev_r <= d[30:0];
				IDX_CUR_UP_DLY: up_dly_r <= d[23:0];
				IDX_CUR_DN_DLY: dn_dly_r <= d[23:0];
				IDX_POS_GAIN: pgain_r <= d[23:0];
				IDX_CORR_TOL: tol_r <= d[7:0];
				IDX_STARTUP_WIN: swin_r <= d[7:0];
				IDX_REL_ORIGIN: if (d[1:0] <= ORIGIN_MAX) origin_r <= d[1:0];
				IDX_LOOP_EN: loop_en_r <= d[0];
				IDX_ARRIVAL_WIN: awin_r <= d[30:0];
				IDX_FILT_WAIT: fwait_r <= d;
				IDX_FILT_SEL: fsel_r <= d;
				IDX_FILT_INT: fint_r <= d;
				IDX_STEP_SUB: if (d[3:0] <= STEP_SUB_MAX) sub_r <= d[3:0];
				IDX_BLANK: blank_r <= d[1:0];
				IDX_CHOP_MODE: mode_r <= d[0];
				IDX_FD_CMP_OFF: cmpoff_r <= d[0];
				IDX_HEND_FDT: hend_r <= d[3:0];
				IDX_HSTR_SOFS: if (d[3:0] <= HSTR_MAX) hstr_r <= d[3:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// initialization sequence after loop enable
	logic [15:0] init_cnt_r;
	wire [15:0] init_len = 16'(INIT_LEN);
	always_ff @(posedge clk_i) begin
		if (rst_i || !loop_en_r) begin
			init_cnt_r <= 16'h0;
			init_done_r <= 1'b0;
		end else if (!init_done_r) begin
			init_cnt_r <= init_cnt_r + 16'h1;
			init_done_r <= (init_cnt_r + 16'h1) >= init_len;
		end
	end
	assign loop_closure_o = loop_en_r;

	////////////////////////////////////////////////////////////////////
	// chopper settings
	// mode select
	// comparator gating only in constant off mode
	assign chop_o.hyst_mode = !mode_r;
	assign chop_o.cmp_ends_decay = !(mode_r && cmpoff_r);
	assign chop_o.hyst_end = mode_r ? 4'h0 : hend_r;
	assign chop_o.fast_decay_time = mode_r ? hend_r : 4'h0;
	assign chop_o.hyst_start = mode_r ? 4'h0 : hstr_r;
	assign chop_o.sine_offset = mode_r ? hstr_r : 4'h0;
	assign chop_o.blank_code = blank_r;
	assign chop_o.usteps_log2_onehot = 9'h1 << sub_r;

	////////////////////////////////////////////////////////////////////
	// position regulation
	// gain split into integer and fraction
	assign applied_gain_int_o = {16'h0, pgain_r[23:POS_GAIN_SHIFT]};
	assign applied_gain_frac_o = pgain_r[POS_GAIN_SHIFT-1:0];
	// most negative deviation stays itself, read as huge
	wire [31:0] dev_abs = pos_dev_i[31] ? 32'(-pos_dev_i) : pos_dev_i;
	assign current_ramp_ok_o = dev_abs > {24'h0, swin_r};
	assign target_reached_o = dev_abs <= {1'b0, awin_r};
	assign rel_origin_o = (origin_r == 2'h0) ? pos_i.target_pos :
		(origin_r == 2'h1) ? pos_i.actual_pos : pos_i.encoder_pos;

	////////////////////////////////////////////////////////////////////
	// velocity limiter
	wire [32:0] vcap = {1'b0, vel_max_i} + {2'b0, vdev_r};
	assign vel_limited_o = ({1'b0, vel_req_i} > vcap) ? vcap[31:0] : vel_req_i;

	logic [31:0] isum_r;
	// 33-bit sum: a large error must clip, never wrap round
	wire signed [32:0] iclip_s = {18'h0, iclip_r};
	wire signed [32:0] iadd = $signed({isum_r[31], isum_r}) +
		$signed({vel_err_i[31], vel_err_i});
	wire signed [32:0] iclamped = (iadd > iclip_s) ? iclip_s :
		(iadd < -iclip_s) ? -iclip_s : iadd;
	logic [14:0] dcnt_r;
	logic dtick_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dcnt_r <= 15'h0;
			dtick_r <= 1'b0;
		end else if (dcnt_r >= ddiv_r) begin
			dcnt_r <= 15'h0;
			dtick_r <= 1'b1;
		end else begin
			dcnt_r <= dcnt_r + 15'h1;
			dtick_r <= 1'b0;
		end
	end
	assign deriv_tick_o = dtick_r;
	// clipped integral sum, zero gain freezes it
	always_ff @(posedge clk_i) begin
		if (rst_i || !loop_en_r)
			isum_r <= 32'h0;
		else if (igain_r != 24'h0)
			isum_r <= iclamped[31:0];
	end
	assign integ_sum_o = isum_r;

	////////////////////////////////////////////////////////////////////
	// current pacing; each step waits its own delay
	logic [23:0] up_cnt_r;
	logic [23:0] dn_cnt_r;
	logic up_stp_r;
	logic dn_stp_r;
	wire up_due = up_cnt_r >= up_dly_r;
	wire dn_due = dn_cnt_r >= dn_dly_r;
	always_ff @(posedge clk_i) begin
		if (rst_i || !loop_en_r) begin
			up_cnt_r <= 24'h0;
			dn_cnt_r <= 24'h0;
			up_stp_r <= 1'b0;
			dn_stp_r <= 1'b0;
		end else begin
			up_stp_r <= cur_up_req_i && current_ramp_ok_o && up_due;
			dn_stp_r <= cur_down_req_i && dn_due;
			up_cnt_r <= (!cur_up_req_i || up_due) ?
				24'h0 : up_cnt_r + 24'h1;
			dn_cnt_r <= (!cur_down_req_i || dn_due) ?
				24'h0 : dn_cnt_r + 24'h1;
		end
	end
	assign cur_up_step_o = up_stp_r;
	assign cur_down_step_o = dn_stp_r;

	////////////////////////////////////////////////////////////////////
	// checks
	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o) else $error("no ack after request");
	ro_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx == IDX_INIT_DONE && loop_en_r == init_done_r
		|=> $stable(init_done_r)) else $error("init flag written");
	loop_en_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && idx == IDX_LOOP_EN |=> loop_closure_o == $past(d[0]))
		else $error("loop enable not stored");
	init_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!loop_en_r |=> !init_done_r) else $error("init flag set while off");
	sub_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sub_r <= STEP_SUB_MAX) else $error("subdivision out of range");
	cmp_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!chop_o.cmp_ends_decay |-> mode_r && cmpoff_r)
		else $error("comparator gated wrongly");
	startup_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dev_abs <= {24'h0, swin_r} |=> !cur_up_step_o)
		else $error("current rose in startup window");
	arrival_a: assert property (@(posedge clk_i) disable iff (rst_i)
		target_reached_o |-> dev_abs <= {1'b0, awin_r})
		else $error("target reached outside window");
	iclip_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$signed(isum_r) <= iclip_s) else $error("integral sum over clip");
	vcap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		{1'b0, vel_limited_o} <= vcap) else $error("velocity over cap");

	////////////////////////////////////////////////////////////////////
	// pacing, range and refusal checks
	tick_due_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dcnt_r >= ddiv_r |=> deriv_tick_o) else $error("tick missing");
	tick_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dcnt_r < ddiv_r |=> !deriv_tick_o) else $error("tick too early");
	up_pace_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_up_step_o |-> $past(cur_up_req_i) && $past(up_due) &&
		$past(current_ramp_ok_o)) else $error("current up not paced");
	dn_pace_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cur_down_step_o |-> $past(cur_down_req_i) && $past(dn_due))
		else $error("current down not paced");
	step_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!loop_en_r |=> !cur_up_step_o && !cur_down_step_o)
		else $error("current step while loop off");
	init_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(loop_en_r) |-> !init_done_r) else $error("init flag early");
	origin_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		origin_r <= ORIGIN_MAX) else $error("origin code out of range");
	hstr_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		hstr_r <= HSTR_MAX) else $error("start offset out of range");
	iclip_lo_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$signed(isum_r) >= -iclip_s) else $error("integral sum under clip");
	part_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req && wb_we_i && wb_sel_i != 4'hf |=> $stable(igain_r))
		else $error("partial write stored");
	ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");
	reach_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dev_abs <= {1'b0, awin_r} |-> target_reached_o)
		else $error("target reached missing");
	vel_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
		vel_limited_o <= vel_req_i) else $error("velocity above request");
endmodule : cla_axis_settings

// File: logic/cla_pkg.sv
// Purpose: constants and carrier types for the axis settings bank
// Assumes: classic wishbone, 32-bit data, word index registers
// Notes: byte address is four times the register index
package cla_pkg;
	localparam logic [7:0] IDX_VL_IGAIN = 8'h74;
	localparam logic [7:0] IDX_VL_ICLIP = 8'h75;
	localparam logic [7:0] IDX_VL_DDIV = 8'h76;
	localparam logic [7:0] IDX_VDEV_CLIP = 8'h77;
	localparam logic [7:0] IDX_CUR_UP_DLY = 8'h78;
	localparam logic [7:0] IDX_CUR_DN_DLY = 8'h79;
	localparam logic [7:0] IDX_POS_GAIN = 8'h7c;
	localparam logic [7:0] IDX_CORR_TOL = 8'h7d;
	localparam logic [7:0] IDX_STARTUP_WIN = 8'h7e;
	localparam logic [7:0] IDX_REL_ORIGIN = 8'h7f;
	localparam logic [7:0] IDX_LOOP_EN = 8'h81;
	localparam logic [7:0] IDX_SPEED_AVG = 8'h83;
	localparam logic [7:0] IDX_SPEED_RAW = 8'h84;
	localparam logic [7:0] IDX_INIT_DONE = 8'h85;
	localparam logic [7:0] IDX_ARRIVAL_WIN = 8'h86;
	localparam logic [7:0] IDX_FILT_WAIT = 8'h88;
	localparam logic [7:0] IDX_FILT_SEL = 8'h89;
	localparam logic [7:0] IDX_FILT_INT = 8'h8a;
	localparam logic [7:0] IDX_STEP_SUB = 8'h8c;
	localparam logic [7:0] IDX_BLANK = 8'ha2;
	localparam logic [7:0] IDX_CHOP_MODE = 8'ha3;
	localparam logic [7:0] IDX_FD_CMP_OFF = 8'ha4;
	localparam logic [7:0] IDX_HEND_FDT = 8'ha5;
	localparam logic [7:0] IDX_HSTR_SOFS = 8'ha6;
	localparam logic [3:0] STEP_SUB_MAX = 4'h8;
	localparam logic [3:0] STEP_SUB_RST = 4'h8;
	localparam logic [3:0] HSTR_MAX = 4'h8;
	localparam logic [14:0] ICLIP_MAX = 15'h7fff;
	localparam logic [1:0] ORIGIN_MAX = 2'h2;
	localparam int POS_GAIN_SHIFT = 16;
	localparam logic [15:0] INIT_CYCLES = 16'h03e8;

	typedef struct packed {
		logic hyst_mode;
		logic cmp_ends_decay;
		logic [3:0] hyst_end;
		logic [3:0] fast_decay_time;
		logic [3:0] hyst_start;
		logic [3:0] sine_offset;
		logic [1:0] blank_code;
		logic [8:0] usteps_log2_onehot;
	} cla_chop_t;

	typedef struct packed {
		logic [31:0] target_pos;
		logic [31:0] actual_pos;
		logic [31:0] encoder_pos;
	} cla_pos_t;
endpackage : cla_pkg

// File: verif/cla_motor_model.sv
// Purpose: motor and encoder stand-in for the axis settings bank
// Assumes: moves come as one-cycle strobes carrying a step delta
// Notes: encoder trails actual by one move, so deviation is live
`timescale 1ns/1ps
module cla_motor_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic move_i,
	input wire logic [31:0] delta_i,
	output cla_pkg::cla_pos_t pos_o,
	output logic [31:0] dev_o,
	output logic [31:0] spd_avg_o,
	output logic [31:0] spd_raw_o
);
	import cla_pkg::*;
	////////////////////////////////////////
	assign dev_o = pos_o.actual_pos - pos_o.encoder_pos;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_o <= '0;
			spd_avg_o <= 32'h0;
			spd_raw_o <= 32'h0;
		end else if (move_i) begin
			pos_o.target_pos <= pos_o.target_pos + delta_i;
			pos_o.actual_pos <= pos_o.target_pos;
			pos_o.encoder_pos <= pos_o.actual_pos;
			spd_raw_o <= delta_i;
			// crude average, enough to differ from raw
			spd_avg_o <= (spd_avg_o + delta_i) >> 1;
		end
	end
endmodule : cla_motor_model

// File: verif/tb_top.sv
// Purpose: self-checking bench for the axis settings bank
// Assumes: init length cut to ten cycles
// Notes: reference kept as a register image
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin \
	n_errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top;
	import cla_pkg::*;
	localparam int INIT = 10;
	localparam logic [7:0] RW [21] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'h78,
		8'h79, 8'h7c, 8'h7d, 8'h7e, 8'h7f, 8'h81, 8'h86, 8'h88, 8'h89,
		8'h8a, 8'h8c, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6};
	logic clk_i, rst_i, cyc, stb, we, mv, cup, cdn, ack, lc, ramp, reach;
	logic [3:0] sel;
	logic [9:0] adr;
	logic [31:0] wdat, q, rdo, dlt, vmax, vreq, verr, dev, sa, sr, org, vl;
	logic tick, ustp, dstp;
	logic [31:0] isum;
	logic [23:0] gi;
	logic [15:0] gf;
	logic [31:0] s = 32'h00000c4d;
	logic [31:0] mdl [256];
	cla_pos_t pos;
	cla_chop_t chop;
	int n_errors = 0;
	int total_checks = 0;
	////////////////////////////////////////
	cla_axis_settings #(.INIT_LEN(INIT)) cla_axis_settings_i (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdo),
		.wb_ack_o(ack), .speed_avg_i(sa), .speed_raw_i(sr), .pos_dev_i(dev),
		.vel_max_i(vmax), .vel_req_i(vreq), .vel_err_i(verr),
		.cur_up_req_i(cup), .cur_down_req_i(cdn), .pos_i(pos), .chop_o(chop),
		.loop_closure_o(lc), .rel_origin_o(org), .applied_gain_int_o(gi),
		.applied_gain_frac_o(gf), .current_ramp_ok_o(ramp),
		.target_reached_o(reach), .vel_limited_o(vl), .integ_sum_o(isum),
		.deriv_tick_o(tick), .cur_up_step_o(ustp),
		.cur_down_step_o(dstp));
	cla_motor_model cla_motor_model_i (.clk_i(clk_i), .rst_i(rst_i),
		.move_i(mv), .delta_i(dlt), .pos_o(pos), .dev_o(dev),
		.spd_avg_o(sa), .spd_raw_o(sr));
	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : rnd
	function automatic int wd(logic [7:0] i);
		case (i)
			8'h74, 8'h78, 8'h79, 8'h7c: return 24;
			8'h75, 8'h76: return 15;
			8'h77, 8'h86: return 31;
			8'h7d, 8'h7e: return 8;
			8'h7f, 8'ha2: return 2;
			8'h81, 8'ha3, 8'ha4: return 1;
			8'h88, 8'h89, 8'h8a: return 32;
			8'h8c, 8'ha5, 8'ha6: return 4;
			default: return 0;
		endcase
	endfunction : wd
	function automatic logic pk(int k);
		return k == 0 ? tick : k == 1 ? ustp : dstp;
	endfunction : pk
	// symmetric clip of the running sum, in wide integers
	function automatic logic [31:0] clip(logic [31:0] a, logic [31:0] e,
		logic [31:0] c);
		longint t;
		t = longint'($signed(a)) + longint'($signed(e));
		if (t > longint'(c))
			t = longint'(c);
		else if (t < -longint'(c))
			t = -longint'(c);
		return 32'(t);
	endfunction : clip
	// waits for one pulse, then counts edges to the next; 64 if none
	task automatic gap(int k, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pk(k) !== 1'b1 && n < 64);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pk(k) !== 1'b1 && n < 64);
	endtask : gap
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test
	task automatic bus(logic [7:0] ix, logic w, logic [31:0] d,
		logic [3:0] sl);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'b00};
		sel <= sl;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		`CHK("ack", 1'b1, ack)
		if (w && sl == 4'hf && wd(ix) > 0 && !(ix == 8'h8c && d > 8) &&
			!(ix == 8'h7f && d > 2) && !(ix == 8'ha6 && d > 8))
			mdl[ix] = d;
	endtask : bus
	task automatic rdchk(logic [7:0] ix, logic [31:0] e);
		bus(ix, 1'b0, 32'h0, 4'hf);
		`CHK("reg", e, q)
	endtask : rdchk
	task automatic stim();
		logic [31:0] r;
		r = rnd();
		@(posedge clk_i);
		vmax <= rnd() >> 2;
		vreq <= rnd();
		verr <= rnd();
		{cup, cdn} <= r[1:0];
		dlt <= (r & 32'h3ff) - 32'h200;
		mv <= 1'b1;
		@(posedge clk_i);
		mv <= 1'b0;
	endtask : stim
	task automatic outs();
		cla_chop_t e;
		logic m;
		logic [31:0] a, v, o;
		@(negedge clk_i);
		m = mdl[8'ha3][0];
		e.hyst_mode = !m;
		e.cmp_ends_decay = !(m && mdl[8'ha4][0]);
		e.hyst_end = m ? 4'h0 : mdl[8'ha5][3:0];
		e.fast_decay_time = m ? mdl[8'ha5][3:0] : 4'h0;
		e.hyst_start = m ? 4'h0 : mdl[8'ha6][3:0];
		e.sine_offset = m ? mdl[8'ha6][3:0] : 4'h0;
		e.blank_code = mdl[8'ha2][1:0];
		e.usteps_log2_onehot = 9'h1 << mdl[8'h8c];
		a = dev[31] ? -dev : dev;
		v = vmax + mdl[8'h77];
		o = mdl[8'h7f] == 0 ? pos.target_pos :
			mdl[8'h7f] == 1 ? pos.actual_pos : pos.encoder_pos;
		`CHK("chop", e, chop)
		`CHK("loop", mdl[8'h81][0], lc)
		`CHK("origin", o, org)
		`CHK("gain", {16'h0, mdl[8'h7c][23:16]}, gi)
		`CHK("frac", mdl[8'h7c][15:0], gf)
		`CHK("ramp", a > mdl[8'h7e], ramp)
		`CHK("reach", a <= mdl[8'h86], reach)
		`CHK("vel", vreq < v ? vreq : v, vl)
	endtask : outs
	////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		finish_test();
	end
	initial begin
		logic [31:0] d;
		logic [31:0] i0, a, x;
		int n;
		rst_i = 1'b1;
		{cyc, stb, we, mv, cup, cdn} = 6'h0;
		{adr, sel, wdat, dlt, vmax, vreq, verr} = '0;
		foreach (mdl[i]) mdl[i] = 32'h0;
		mdl[8'h8c] = 32'h8;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int p = 0; p < 4; p++) begin
			foreach (RW[k]) begin
				d = rnd() & ((wd(RW[k]) == 32) ? 32'hffffffff :
					(32'h1 << wd(RW[k])) - 32'h1);
				if (p > 0 && RW[k] != 8'h81)
					bus(RW[k], 1'b1, RW[k] == 8'h86 ? d & 32'h3ff : d, 4'hf);
			end
			bus(8'h83, 1'b1, rnd(), 4'hf);
			bus(8'h85, 1'b1, 32'h1, 4'hf);
			bus(8'h80, 1'b1, rnd(), 4'hf);
			bus(8'h74, 1'b1, rnd() & 32'hffff, 4'h3);
			stim();
			outs();
			foreach (RW[k]) rdchk(RW[k], mdl[RW[k]]);
			rdchk(8'h80, 32'h0);
			rdchk(8'h83, sa);
			rdchk(8'h84, sr);
			rdchk(8'h85, 32'h0);
		end
		bus(8'h8c, 1'b1, 32'h8, 4'hf);
		bus(8'h81, 1'b1, 32'h1, 4'hf);
		rdchk(8'h85, 32'h0);
		repeat (2 * INIT) @(posedge clk_i);
		rdchk(8'h85, 32'h1);
		stim();
		outs();
		// small divider and delays so each period fits the wait
		bus(8'h76, 1'b1, rnd() & 32'h1f, 4'hf);
		gap(0, n);
		`CHK("dtick", mdl[8'h76] + 32'h1, n)
		bus(8'h7e, 1'b1, 32'h0, 4'hf);
		bus(8'h78, 1'b1, rnd() & 32'h1f, 4'hf);
		bus(8'h79, 1'b1, rnd() & 32'h1f, 4'hf);
		@(posedge clk_i);
		{cup, cdn} <= 2'b11;
		a = dev[31] ? -dev : dev;
		x = a > mdl[8'h7e] ? mdl[8'h78] + 32'h1 : 32'h40;
		gap(1, n);
		`CHK("up", x, n)
		gap(2, n);
		`CHK("down", mdl[8'h79] + 32'h1, n)
		repeat (4) begin
			@(posedge clk_i);
			verr <= (rnd() & 32'hffff) - 32'h8000;
			@(posedge clk_i);
			i0 = isum;
			x = mdl[8'h74] != 0 ? clip(i0, verr, mdl[8'h75]) : i0;
			@(posedge clk_i);
			`CHK("isum", x, isum)
		end
		@(posedge clk_i);
		{cup, cdn} <= 2'b00;
		bus(8'h81, 1'b1, 32'h0, 4'hf);
		rdchk(8'h85, 32'h0);
		outs();
		finish_test();
	end
endmodule : tb_top
